// [embp_consts.vh]
`ifndef EMBP_CONSTS_VH
`define EMBP_CONSTS_VH
// ==========================================================
// bus widths
`define EMBP_ADDR_W 16
`define EMBP_DATA_W 16
// ==========================================================
// pin sharing: bit positions of the shared address groups
`define EMBP_PE_LO 6
`define EMBP_PE_HI 7
`define EMBP_PA_LO 8
`define EMBP_PA_HI 15
// ==========================================================
// reset values
`define EMBP_ADDR_RST 16'h0000
`define EMBP_DATA_RST 16'h0000
// ==========================================================
// timing: strobe low time in clock cycles
`define EMBP_STROBE_CYC 2
`endif

// [embp_pin_mux.v]
`timescale 1ns/10ps
// ==========================================================
// per-pin choice between address output and general purpose I/O
module embp_pin_mux #(
  parameter WIDTH = 8
) (
  input  wire [WIDTH-1:0] i_gpio_sel,
  input  wire [WIDTH-1:0] i_addr,
  input  wire [WIDTH-1:0] i_addr_oe,
  input  wire [WIDTH-1:0] i_gpio_out,
  input  wire [WIDTH-1:0] i_gpio_oe,
  output wire [WIDTH-1:0] o_pin_out,
  output wire [WIDTH-1:0] o_pin_oe
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
      assign o_pin_out[g] = i_gpio_sel[g] ? i_gpio_out[g] : i_addr[g];
      assign o_pin_oe[g]  = i_gpio_sel[g] ? i_gpio_oe[g] : i_addr_oe[g];
    end
  endgenerate
endmodule // embp_pin_mux

// [embp_port.v]
`timescale 1ns/10ps
`include "embp_consts.vh"
module embp_port #(
  parameter STROBE_CYC = `EMBP_STROBE_CYC
) (
  input  wire                    i_clock,
  input  wire                    i_rst,
  input  wire                    i_req,
  input  wire                    i_write,
  input  wire                    i_data_space,
  input  wire [`EMBP_ADDR_W-1:0] i_addr,
  input  wire [`EMBP_DATA_W-1:0] i_wdata,
  input  wire [`EMBP_DATA_W-1:0] i_ext_data_in,
  input  wire [1:0]              i_port_e_sel,
  input  wire [1:0]              i_port_e_out,
  input  wire [1:0]              i_port_e_oe,
  input  wire [7:0]              i_port_a_sel,
  input  wire [7:0]              i_port_a_out,
  input  wire [7:0]              i_port_a_oe,
  output reg                     o_busy,
  output reg                     o_done,
  output reg  [`EMBP_DATA_W-1:0] o_rdata,
  output reg  [`EMBP_ADDR_W-1:0] o_ext_addr,
  output reg  [`EMBP_ADDR_W-1:0] o_ext_addr_oe,
  output reg  [`EMBP_DATA_W-1:0] o_ext_data_out,
  output reg                     o_ext_data_oe,
  output reg                     o_program_space_select_n,
  output reg                     o_data_space_select_n,
  output reg                     o_write_strobe_n,
  output reg                     o_read_strobe_n,
  output reg                     o_ctrl_oe
);
  // ==========================================================
  // state
  localparam ST_IDLE  = 2'b00;
  localparam ST_SETUP = 2'b01;
  localparam ST_STRB  = 2'b10;
  localparam ST_HOLD  = 2'b11;

  reg [1:0]              state_r;
  reg [1:0]              state_nxt;
  reg [7:0]              cnt_r;
  reg                    write_r;
  reg                    dspace_r;
  reg [`EMBP_ADDR_W-1:0] addr_r;
  reg [`EMBP_DATA_W-1:0] wdata_r;
  reg                    mux_ready_r;

  // look-ahead of the access fields so the pins move with the selects
  wire                    take      = (state_r == ST_IDLE) && i_req;
  wire [`EMBP_ADDR_W-1:0] addr_nxt  = take ? i_addr : addr_r;
  wire [`EMBP_DATA_W-1:0] wdata_nxt = take ? i_wdata : wdata_r;

  // ==========================================================
  // shared pin muxing; selects ignored until the first clock after reset
  wire [1:0] pe_sel = mux_ready_r ? i_port_e_sel : 2'h0;
  wire [7:0] pa_sel = mux_ready_r ? i_port_a_sel : 8'h00;
  wire [1:0] pe_out;
  wire [1:0] pe_oe;
  wire [7:0] pa_out;
  wire [7:0] pa_oe;
  wire [1:0] a_oe_e = {2{mux_ready_r}};
  wire [7:0] a_oe_a = {8{mux_ready_r}};

  embp_pin_mux #(.WIDTH(2)) u_mux_e (
    .i_gpio_sel (pe_sel),
    .i_addr     (addr_nxt[`EMBP_PE_HI:`EMBP_PE_LO]),
    .i_addr_oe  (a_oe_e),
    .i_gpio_out (i_port_e_out),
    .i_gpio_oe  (i_port_e_oe),
    .o_pin_out  (pe_out),
    .o_pin_oe   (pe_oe)
  );

  embp_pin_mux #(.WIDTH(8)) u_mux_a (
    .i_gpio_sel (pa_sel),
    .i_addr     (addr_nxt[`EMBP_PA_HI:`EMBP_PA_LO]),
    .i_addr_oe  (a_oe_a),
    .i_gpio_out (i_port_a_out),
    .i_gpio_oe  (i_port_a_oe),
    .o_pin_out  (pa_out),
    .o_pin_oe   (pa_oe)
  );

  // ==========================================================
  // access sequencer: setup, strobe low, hold
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (i_req) state_nxt = ST_SETUP;
      ST_SETUP: state_nxt = ST_STRB;
      ST_STRB:  if (cnt_r == 8'h01) state_nxt = ST_HOLD;
      ST_HOLD:  state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_r     <= ST_IDLE;
      cnt_r       <= 8'h00;
      write_r     <= 1'b0;
      dspace_r    <= 1'b0;
      addr_r      <= `EMBP_ADDR_RST;
      wdata_r     <= `EMBP_DATA_RST;
      mux_ready_r <= 1'b0;
    end else begin
      mux_ready_r <= 1'b1;
      state_r     <= state_nxt;
      if (state_r == ST_IDLE && i_req) begin
        write_r  <= i_write;
        dspace_r <= i_data_space;
        addr_r   <= i_addr;
        wdata_r  <= i_wdata;
      end
      if (state_r == ST_SETUP)
        cnt_r <= STROBE_CYC[7:0];
      else if (state_r == ST_STRB)
        cnt_r <= cnt_r - 8'h01;
    end
  end

  // ==========================================================
  // registered pin drivers; everything floats during reset
  wire active      = (state_nxt != ST_IDLE);
  wire strobe      = (state_nxt == ST_STRB);
  wire last_strobe = (state_r == ST_STRB) && (cnt_r == 8'h01);

  // the access fields arrive on the edge that starts setup, so the
  // pins look ahead instead of waiting one cycle for the latches
  function pick_nx;
    input now_val;
    input held_val;
    begin
      pick_nx = (state_r == ST_IDLE) ? now_val : held_val;
    end
  endfunction

  wire write_nxt  = pick_nx(i_write, write_r);
  wire dspace_nxt = pick_nx(i_data_space, dspace_r);

  // ==========================================================
  // status flags toward the core
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_busy <= active | (state_r != ST_IDLE);
      o_done <= (state_r == ST_HOLD);
    end
  end

  // ==========================================================
  // address pins; enables wait one cycle after reset so the shared
  // pins never flip between owners while reset is being released
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_ext_addr    <= `EMBP_ADDR_RST;
      o_ext_addr_oe <= {`EMBP_ADDR_W{1'b0}};
    end else begin
      o_ext_addr    <= {pa_out, pe_out, addr_nxt[5:0]};
      o_ext_addr_oe <= {pa_oe, pe_oe, {6{mux_ready_r}}};
    end
  end

  // ==========================================================
  // bus control pins; selects span setup, strobe and hold so they
  // frame the strobe on both sides
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_program_space_select_n <= 1'b1;
      o_data_space_select_n    <= 1'b1;
      o_write_strobe_n         <= 1'b1;
      o_read_strobe_n          <= 1'b1;
      o_ctrl_oe                <= 1'b0;
    end else begin
      o_program_space_select_n <= ~(active & ~dspace_nxt);
      o_data_space_select_n    <= ~(active & dspace_nxt);
      o_write_strobe_n         <= ~(strobe & write_nxt);
      o_read_strobe_n          <= ~(strobe & ~write_nxt);
      o_ctrl_oe                <= 1'b1;
    end
  end

  // ==========================================================
  // data pins; driven only while a write is in progress, otherwise
  // released so the pull-ups hold the bus
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_ext_data_out <= `EMBP_DATA_RST;
      o_ext_data_oe  <= 1'b0;
    end else begin
      o_ext_data_out <= wdata_nxt;
      o_ext_data_oe  <= active & write_nxt;
    end
  end

  // ==========================================================
  // read capture in the last strobe-low cycle, the edge on which the
  // read strobe rises; memory data is still on the bus there
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= `EMBP_DATA_RST;
    end else if (last_strobe && !write_r) begin
      o_rdata <= i_ext_data_in;
    end
  end

endmodule // embp_port

// [embp_port_asserts.sv]
`timescale 1ns/10ps
`include "embp_consts.vh"
// ==========================================================
// checker on the bus pins of embp_port
module embp_port_asserts (
  input wire                    i_clock,
  input wire                    i_rst,
  input wire                    i_req,
  input wire                    i_data_space,
  input wire [`EMBP_ADDR_W-1:0] i_addr,
  input wire                    o_busy,
  input wire [`EMBP_ADDR_W-1:0] o_ext_addr,
  input wire                    o_ext_data_oe,
  input wire                    o_program_space_select_n,
  input wire                    o_data_space_select_n,
  input wire                    o_write_strobe_n,
  input wire                    o_read_strobe_n
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire ps_n = o_program_space_select_n;
  wire ds_n = o_data_space_select_n;
  wire wr_n = o_write_strobe_n;
  wire rd_n = o_read_strobe_n;
  // two idle cycles so the tail of an access is not misread
  idle_float_a: assert property ($past(!o_busy) && !o_busy |-> !o_ext_data_oe) else $error("data driven while idle");
  wr_drive_a: assert property (!wr_n |-> o_ext_data_oe) else $error("write data not driven");
  rd_input_a: assert property (!rd_n |-> !o_ext_data_oe) else $error("data driven during read");
  one_sel_a: assert property (!(wr_n && rd_n) |-> ps_n ^ ds_n) else $error("space select wrong");
  one_strobe_a: assert property (wr_n || rd_n) else $error("both strobes low");
  sel_space_a: assert property (i_req && !o_busy |=> ds_n == !$past(i_data_space)) else $error("wrong space");
  addr_out_a: assert property (i_req && !o_busy |=> o_ext_addr == $past(i_addr)) else $error("wrong address");
  wr_cycle_a: assert property ($fell(wr_n) |-> ($stable(o_ext_addr) && !wr_n) [*2] ##1 wr_n) else $error("write strobe bad");
  rd_cycle_a: assert property ($fell(rd_n) |-> ($stable(o_ext_addr) && !rd_n) [*2] ##1 rd_n) else $error("read strobe bad");
  cover property ($rose(wr_n));
  cover property ($rose(rd_n));
  cover property ($fell(ds_n));
endmodule // embp_port_asserts
bind embp_port embp_port_asserts u_embp_port_asserts (.*);

// [embp_mem_model.sv]
`timescale 1ns/10ps
// ==========================================================
// static ram on both spaces, 256 words each, pulled-up bus
module embp_mem_model (
  input  wire [15:0] i_addr,
  input  wire [15:0] i_data_out,
  input  wire        i_data_oe,
  input  wire        i_ps_n,
  input  wire        i_ds_n,
  input  wire        i_wr_n,
  input  wire        i_rd_n,
  output wire [15:0] o_bus
);
  reg [15:0] pmem [0:255];
  reg [15:0] dmem [0:255];
  always @(posedge i_wr_n) begin
    if (!i_ps_n) pmem[i_addr[7:0]] <= i_data_out;
    else if (!i_ds_n) dmem[i_addr[7:0]] <= i_data_out;
  end
  // released bus floats to the pull-up level
  assign o_bus = i_data_oe ? i_data_out :
    (!i_rd_n && !i_ps_n) ? pmem[i_addr[7:0]] :
    (!i_rd_n && !i_ds_n) ? dmem[i_addr[7:0]] : 16'hFFFF;
endmodule // embp_mem_model

// [embp_port_tb_top.sv]
`timescale 1ns/10ps
module embp_port_tb_top;
  reg         i_clock = 0, i_rst = 1, i_req = 0, i_write = 0;
  reg         i_data_space = 0;
  reg  [15:0] i_addr = 16'h0000, i_wdata = 16'h0000;
  reg  [1:0]  i_port_e_sel = 0, i_port_e_out = 0, i_port_e_oe = 0;
  reg  [7:0]  i_port_a_sel = 0, i_port_a_out = 0, i_port_a_oe = 0;
  wire [15:0] i_ext_data_in, o_rdata, o_ext_addr, o_ext_addr_oe;
  wire [15:0] o_ext_data_out;
  wire        o_busy, o_done, o_ext_data_oe, o_program_space_select_n;
  wire        o_data_space_select_n, o_write_strobe_n, o_read_strobe_n;
  wire        o_ctrl_oe;
  wire [2:0]  sel_pins = {o_busy, o_program_space_select_n,
                          o_data_space_select_n};
  integer     err_total = 0, checks = 0;
  embp_port u_embp_port (.*);
  embp_mem_model u_embp_mem_model (.i_addr(o_ext_addr),
    .i_data_out(o_ext_data_out), .i_data_oe(o_ext_data_oe),
    .i_ps_n(o_program_space_select_n), .i_ds_n(o_data_space_select_n),
    .i_wr_n(o_write_strobe_n), .i_rd_n(o_read_strobe_n),
    .o_bus(i_ext_data_in));
  initial forever #20 i_clock = ~i_clock;
  // ========================================================
  task chk(input string nm, input [15:0] e, input [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0s exp %h got %h", nm, e, g);
    end
  endtask
  task acc(input w, input ds, input [15:0] a, input [15:0] d);
    integer n;
    @(posedge i_clock); #1;
    {i_req, i_write, i_data_space, i_addr, i_wdata} = {1'b1, w, ds, a, d};
    @(posedge i_clock); #1 i_req = 0;
    chk("busy sel", {1'b1, ds, !ds}, sel_pins);
    chk("addr", a, o_ext_addr);
    chk("data oe", w, o_ext_data_oe);
    if (w) chk("wdata", d, o_ext_data_out);
    for (n = 0; n < 20 && o_done !== 1'b1; n++) @(posedge i_clock) #1;
    chk("done", 1, o_done);
    chk("data float", 0, o_ext_data_oe);
  endtask
  task t_spaces;
    acc(1, 0, 16'h0012, 16'hA5C3);
    acc(1, 1, 16'h0012, 16'h3C5A);
    acc(0, 0, 16'h0012, 16'h0000);
    chk("prog rdata", 16'hA5C3, o_rdata);
    acc(0, 1, 16'h0012, 16'h0000);
    chk("data rdata", 16'h3C5A, o_rdata);
  endtask
  task t_gpio;
    @(posedge i_clock); #1;
    {i_port_a_sel, i_port_a_oe, i_port_e_sel} = {8'hF0, 8'hA0, 2'h1};
    {i_port_a_out, i_port_e_out} = {8'h30, 2'h3};
    repeat (3) @(posedge i_clock); #1;
    chk("addr oe gpio", 16'hAFBF, o_ext_addr_oe);
    chk("addr gpio", 16'h3052, o_ext_addr);
    {i_port_a_sel, i_port_e_sel} = 0;
    repeat (3) @(posedge i_clock); #1;
    chk("addr oe back", 16'hFFFF, o_ext_addr_oe);
    chk("addr back", 16'h0012, o_ext_addr);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ========================================================
  initial begin
    repeat (10) @(posedge i_clock); #1;
    chk("float", 16'h0000, {o_ctrl_oe, o_ext_data_oe, o_ext_addr_oe[13:0]});
    i_rst = 0;
    repeat (2) @(posedge i_clock); #1;
    chk("addr oe rst", 16'hFFFF, o_ext_addr_oe);
    chk("ctrl oe", 1, o_ctrl_oe);
    t_spaces;
    t_gpio;
    report_and_stop;
  end
  // whole run needs well under 100 cycles of accesses
  initial begin
    #100000;
    err_total++;
    report_and_stop;
  end
endmodule // embp_port_tb_top
